// >>> logic/sps_pkg.sv
// shared constants and carrier types for the synthesizer phase and spread control
package sps_pkg;

  // core clock rate in hertz (5 ns period)
  localparam longint unsigned CLK_HZ        = 64'd200_000_000;

  // byte addresses of the register map; the lower address holds the upper byte
  localparam logic [15:0] ADDR_PHASE_HI     = 16'h0690;
  localparam logic [15:0] ADDR_PHASE_LO     = 16'h0691;
  localparam logic [15:0] ADDR_SPREAD_CFG   = 16'h0694;
  localparam logic [15:0] ADDR_RATE_HI      = 16'h0695;
  localparam logic [15:0] ADDR_RATE_LO      = 16'h0696;
  localparam logic [15:0] ADDR_DEPTH        = 16'h0697;

  // reset values
  localparam logic [15:0] PHASE_RST         = 16'h0000;
  localparam logic [7:0]  SPREAD_CFG_RST    = 8'h00;
  localparam logic [15:0] RATE_RST          = 16'h0000;
  localparam logic [7:0]  DEPTH_RST         = 8'h00;

  // field position of the sweep mode bit (0 centre, 1 down)
  localparam int          MODE_BIT          = 0;

  // modulation rate in 250 Hz steps and its legal span
  localparam longint unsigned RATE_UNIT_HZ  = 64'd250;
  localparam logic [15:0] RATE_MIN          = 16'h0064;
  localparam logic [15:0] RATE_MAX          = 16'h00DC;

  // peak-to-peak depth in 0.025 percent steps and its legal span
  localparam logic [7:0]  DEPTH_MIN         = 8'h01;
  localparam logic [7:0]  DEPTH_MAX         = 8'hC8;

  // sweep phase accumulator step per rate count: 2^32 * 250 / clock, rounded
  localparam longint unsigned ACC_STEP_L    =
    ((64'd1 << 32) * RATE_UNIT_HZ + CLK_HZ / 64'd2) / CLK_HZ;
  localparam logic [15:0] ACC_STEP          = ACC_STEP_L[15:0];

  // quarter turn of the accumulator, used to start centre mode at nominal
  localparam logic [31:0] ACC_QUARTER       = 32'h4000_0000;

  // extra phase offset: 389000 / vco * (12 - vco) / vco, vco in GHz;
  // with vco in MHz this is 389000000 * (12000 - vco) / vco^2
  localparam logic [47:0] EXTRA_NUM_K       = 48'h0000_172F_AB40;
  localparam logic [15:0] EXTRA_VCO_KNEE    = 16'h2EE0;
  localparam int          DIV_BITS          = 48;
  localparam logic [5:0]  DIV_LAST          = 6'h2F;
  localparam logic [15:0] EXTRA_CLAMP       = 16'h7FFF;

  // one byte-wide register access, used by the host port and the flash loader
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } sps_wr_t;

  // sequencer for the turn-on phase shift
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_DIV   = 2'b01,
    PH_APPLY = 2'b10
  } sps_ph_state_t;

endpackage : sps_pkg

// >>> logic/sps_sweep.sv
// triangular frequency sweep generator for one synthesizer
`timescale 1ns/1ps
module sps_sweep (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // configuration and run control
  input  wire logic               run,
  input  wire logic               mode_down,
  input  wire logic [7:0]         depth,
  input  wire logic [15:0]        rate,
  // sweep output, signed, in units of 0.025 percent / 256
  output logic signed [17:0]      freq_offset_r,
  output logic                    active_r
);

  logic [31:0]        acc_r;        // position within one modulation period
  logic [31:0]        acc_nxt;
  logic signed [17:0] offset_nxt;
  logic               go;           // configuration legal and synth running
  logic [31:0]        ph;           // accumulator seen through the mode shift
  logic [15:0]        tri_w;        // folded triangle, 0 to nearly 1
  logic [23:0]        prod;         // depth times triangle
  logic [15:0]        dip;          // drop below the sweep's upper reference

  // out-of-range settings hold the synth at nominal rather than sweep wildly
  assign go = run && (rate >= sps_pkg::RATE_MIN) && (rate <= sps_pkg::RATE_MAX) // [R11]
           && (depth >= sps_pkg::DEPTH_MIN) && (depth <= sps_pkg::DEPTH_MAX);    // [R12]

  // next accumulator and next offset
  always_comb
  begin
    acc_nxt    = acc_r;
    offset_nxt = 18'sh00000;
    // centre mode starts a quarter turn in, which lands on nominal
    ph    = mode_down ? acc_r : acc_r + sps_pkg::ACC_QUARTER;
    tri_w = ph[31] ? ~ph[30:15] : ph[30:15];
    prod  = depth * tri_w;                                    // [R09]
    dip   = prod[23:8];
    if (!go)
    begin
      // idle: park at the period start so the next sweep begins at nominal
      acc_nxt = 32'h0000_0000;                                // [R06]
    end
    else
    begin
      // one period is 2^32 / (rate * step) cycles, i.e. 1 / (rate * 250 Hz)
      // widen both factors first: the product overflows 16 bits
      acc_nxt = acc_r + (32'(rate) * 32'(sps_pkg::ACC_STEP)); // [R10]
      if (mode_down)
      begin
        // straight down the full spread and back up
        offset_nxt = -$signed({2'b00, dip});                  // [R08]
      end
      else
      begin
        // half down, full up, half down: triangle centred on nominal
        offset_nxt = $signed({3'b000, depth, 7'h00}) - $signed({2'b00, dip}); // [R07]
      end
    end
  end

  // registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      acc_r         <= 32'h0000_0000;
      freq_offset_r <= 18'sh00000;
      active_r      <= 1'b0;
    end
    else
    begin
      acc_r         <= acc_nxt;
      freq_offset_r <= offset_nxt;
      active_r      <= go;
    end
  end

endmodule : sps_sweep

// >>> logic/sps_ctrl.sv
// per-synthesizer register file, turn-on phase shift and spread control
// What this block does
// [R01] shift phase by offset setting at turn-on
// [R02] offset is signed 16 bits, 1 ps
// [R03] after first nonzero write add VCO extra offset
// [R04] software may pre-add extra offset itself
// [R05] no extra offset after flash or reset load
// [R06] each sweep starts at nominal frequency
// [R07] centre mode: half down, full up, back
// [R08] down mode: full down, then back up
// [R09] sweep amplitude from depth setting
// [R10] modulation period from two-byte rate setting
// [R11] rate in 250 Hz steps, 100 to 220
// [R12] depth in 0.025% steps, 1 to 200
// [R13] phase shift applied once per turn-on
`timescale 1ns/1ps
module sps_ctrl (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // host register port, byte wide
  input  sps_pkg::sps_wr_t        host_wr,
  input  wire logic               host_rd_en,
  input  wire logic [15:0]        host_rd_addr,
  output logic [7:0]              host_rd_data_r,
  // configuration loader port (flash image or loaded file)
  input  sps_pkg::sps_wr_t        load_wr,
  // synthesizer state
  input  wire logic               synth_on,
  input  wire logic [15:0]        vco_mhz,
  // phase shift request toward the synthesizer
  output logic                    phase_apply_r,
  output logic signed [17:0]      phase_shift_r,
  output logic                    extra_armed_r,
  // spread spectrum output
  output logic signed [17:0]      freq_offset_r,
  output logic                    sweep_active_r
);

  // register file
  logic [15:0] phase_r, phase_nxt;      // signed ps offset
  logic        mode_r,  mode_nxt;       // spread mode bit
  logic [15:0] rate_r,  rate_nxt;       // rate in 250 Hz steps
  logic [7:0]  depth_r, depth_nxt;      // depth in 0.025 % steps
  logic        armed_nxt;               // extra offset now present
  logic [7:0]  rd_nxt;

  // turn-on sequencer
  sps_pkg::sps_ph_state_t st_r, st_nxt;
  logic        on_d_r;                  // synth_on one cycle ago
  logic        on_rise;
  logic [47:0] num_r,  num_nxt;         // dividend, shifted out msb first
  logic [48:0] rem_r,  rem_nxt;         // partial remainder
  logic [47:0] quo_r,  quo_nxt;         // quotient bits
  logic [31:0] den_r,  den_nxt;         // vco squared
  logic        neg_r,  neg_nxt;         // vco above the 12 GHz knee
  logic [5:0]  cnt_r,  cnt_nxt;         // divide step counter
  logic        apply_nxt;
  logic signed [17:0] shift_nxt;
  logic [48:0] rem_sh;                  // remainder with next dividend bit
  logic [15:0] mag;                     // clamped extra offset magnitude
  logic signed [17:0] extra_s;          // signed extra offset

  // write decode: host and loader write the same storage; only a host write
  // of a nonzero phase arms the extra offset, matching the silicon quirk
  always_comb
  begin
    phase_nxt = phase_r;
    mode_nxt  = mode_r;
    rate_nxt  = rate_r;
    depth_nxt = depth_r;
    armed_nxt = extra_armed_r;
    // loader first so that a host write in the same cycle takes precedence
    if (load_wr.en)
    begin
      case (load_wr.addr)
        sps_pkg::ADDR_PHASE_HI:   phase_nxt[15:8] = load_wr.data; // [R05]
        sps_pkg::ADDR_PHASE_LO:   phase_nxt[7:0]  = load_wr.data; // [R05]
        sps_pkg::ADDR_SPREAD_CFG: mode_nxt        = load_wr.data[sps_pkg::MODE_BIT];
        sps_pkg::ADDR_RATE_HI:    rate_nxt[15:8]  = load_wr.data;
        sps_pkg::ADDR_RATE_LO:    rate_nxt[7:0]   = load_wr.data;
        sps_pkg::ADDR_DEPTH:      depth_nxt       = load_wr.data;
        default:                  ;                // unmapped: ignored
      endcase
    end
    if (host_wr.en)
    begin
      case (host_wr.addr)
        sps_pkg::ADDR_PHASE_HI:   phase_nxt[15:8] = host_wr.data;
        sps_pkg::ADDR_PHASE_LO:   phase_nxt[7:0]  = host_wr.data;
        sps_pkg::ADDR_SPREAD_CFG: mode_nxt        = host_wr.data[sps_pkg::MODE_BIT];
        sps_pkg::ADDR_RATE_HI:    rate_nxt[15:8]  = host_wr.data;
        sps_pkg::ADDR_RATE_LO:    rate_nxt[7:0]   = host_wr.data;
        sps_pkg::ADDR_DEPTH:      depth_nxt       = host_wr.data;
        default:                  ;                // unmapped: ignored
      endcase
      // sticky once armed; only reset clears it again
      if (((host_wr.addr == sps_pkg::ADDR_PHASE_HI) ||
           (host_wr.addr == sps_pkg::ADDR_PHASE_LO)) && (phase_nxt != 16'h0000))
      begin
        armed_nxt = 1'b1;                                        // [R03]
      end
    end
  end

  // read mux: reserved mode-register bits and unmapped bytes read zero
  always_comb
  begin
    rd_nxt = host_rd_data_r;
    if (host_rd_en)
    begin
      case (host_rd_addr)
        sps_pkg::ADDR_PHASE_HI:   rd_nxt = phase_r[15:8];
        sps_pkg::ADDR_PHASE_LO:   rd_nxt = phase_r[7:0];
        sps_pkg::ADDR_SPREAD_CFG: rd_nxt = {7'h00, mode_r};
        sps_pkg::ADDR_RATE_HI:    rd_nxt = rate_r[15:8];
        sps_pkg::ADDR_RATE_LO:    rd_nxt = rate_r[7:0];
        sps_pkg::ADDR_DEPTH:      rd_nxt = depth_r;
        default:                  rd_nxt = 8'h00;
      endcase
    end
  end

  // register file storage
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_r        <= sps_pkg::PHASE_RST;
      mode_r         <= sps_pkg::SPREAD_CFG_RST[sps_pkg::MODE_BIT];
      rate_r         <= sps_pkg::RATE_RST;
      depth_r        <= sps_pkg::DEPTH_RST;
      extra_armed_r  <= 1'b0;                                    // [R05]
      host_rd_data_r <= 8'h00;
    end
    else
    begin
      phase_r        <= phase_nxt;
      mode_r         <= mode_nxt;
      rate_r         <= rate_nxt;
      depth_r        <= depth_nxt;
      extra_armed_r  <= armed_nxt;
      host_rd_data_r <= rd_nxt;
    end
  end

  // turn-on detection; synth_on is a same-clock level so no synchroniser
  assign on_rise = synth_on && !on_d_r;

  // extra offset from the quotient, clamped to the 16-bit signed span
  assign mag     = (quo_r > {32'h0000_0000, sps_pkg::EXTRA_CLAMP}) ?
                   sps_pkg::EXTRA_CLAMP : quo_r[15:0];
  assign extra_s = neg_r ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
  assign rem_sh  = {rem_r[47:0], num_r[47]};

  // turn-on sequencer: one restoring divide step per cycle, so the shift
  // lands about 50 cycles after an armed turn-on, 2 cycles after a plain one; area traded for latency
  always_comb
  begin
    st_nxt    = st_r;
    num_nxt   = num_r;
    rem_nxt   = rem_r;
    quo_nxt   = quo_r;
    den_nxt   = den_r;
    neg_nxt   = neg_r;
    cnt_nxt   = cnt_r;
    apply_nxt = 1'b0;
    shift_nxt = phase_shift_r;
    case (st_r)
      sps_pkg::PH_IDLE:
      begin
        // only the rising edge counts; a running synth is left alone
        if (on_rise)                                             // [R13]
        begin
          neg_nxt = (vco_mhz > sps_pkg::EXTRA_VCO_KNEE);
          num_nxt = sps_pkg::EXTRA_NUM_K * 48'(neg_nxt ?
                    (vco_mhz - sps_pkg::EXTRA_VCO_KNEE) :
                    (sps_pkg::EXTRA_VCO_KNEE - vco_mhz));
          den_nxt = vco_mhz * vco_mhz;
          rem_nxt = 49'h0;
          quo_nxt = 48'h0;
          cnt_nxt = 6'h00;
          // no division needed when unarmed or with no vco figure
          if (extra_armed_r && (vco_mhz != 16'h0000))
          begin
            st_nxt = sps_pkg::PH_DIV;
          end
          else
          begin
            st_nxt = sps_pkg::PH_APPLY;
          end
        end
      end
      sps_pkg::PH_DIV:
      begin
        num_nxt = {num_r[46:0], 1'b0};
        if (rem_sh >= {17'h0, den_r})
        begin
          rem_nxt = rem_sh - {17'h0, den_r};
          quo_nxt = {quo_r[46:0], 1'b1};
        end
        else
        begin
          rem_nxt = rem_sh;
          quo_nxt = {quo_r[46:0], 1'b0};
        end
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == sps_pkg::DIV_LAST)
        begin
          st_nxt = sps_pkg::PH_APPLY;
        end
      end
      sps_pkg::PH_APPLY:
      begin
        // signed ps setting plus the extra offset when armed
        shift_nxt = $signed({{2{phase_r[15]}}, phase_r})          // [R02]
                  + (extra_armed_r ? extra_s : 18'sh00000);       // [R03]
        apply_nxt = 1'b1;                                        // [R01]
        st_nxt    = sps_pkg::PH_IDLE;
      end
      default:
      begin
        st_nxt = sps_pkg::PH_IDLE;
      end
    endcase
    // quotient of an unarmed pass must not leak into the sum
    if ((st_r == sps_pkg::PH_IDLE) && on_rise && !extra_armed_r)
    begin
      quo_nxt = 48'h0;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r          <= sps_pkg::PH_IDLE;
      on_d_r        <= 1'b0;
      num_r         <= 48'h0;
      rem_r         <= 49'h0;
      quo_r         <= 48'h0;
      den_r         <= 32'h0;
      neg_r         <= 1'b0;
      cnt_r         <= 6'h00;
      phase_apply_r <= 1'b0;
      phase_shift_r <= 18'sh00000;
    end
    else
    begin
      st_r          <= st_nxt;
      on_d_r        <= synth_on;
      num_r         <= num_nxt;
      rem_r         <= rem_nxt;
      quo_r         <= quo_nxt;
      den_r         <= den_nxt;
      neg_r         <= neg_nxt;
      cnt_r         <= cnt_nxt;
      phase_apply_r <= apply_nxt;
      phase_shift_r <= shift_nxt;
    end
  end

  // spread spectrum sweep runs while the synth is on
  sps_sweep u_sweep (
    .core_clk      (core_clk),
    .rst           (rst),
    .run           (synth_on),
    .mode_down     (mode_r),          // [R07] [R08]
    .depth         (depth_r),         // [R09]
    .rate          (rate_r),          // [R10]
    .freq_offset_r (freq_offset_r),
    .active_r      (sweep_active_r)
  );

endmodule : sps_ctrl

// >>> test/sps_ctrl_assertions.sv
// port checker for the phase and spread control
`timescale 1ns/1ps
module sps_ctrl_assertions (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // host and loader ports
  input  sps_pkg::sps_wr_t        host_wr,
  input  wire logic               host_rd_en,
  input  wire logic [15:0]        host_rd_addr,
  input  wire logic [7:0]         host_rd_data_r,
  input  sps_pkg::sps_wr_t        load_wr,
  // synthesizer side
  input  wire logic               synth_on,
  input  wire logic [15:0]        vco_mhz,
  input  wire logic               phase_apply_r,
  input  wire logic signed [17:0] phase_shift_r,
  input  wire logic               extra_armed_r,
  input  wire logic signed [17:0] freq_offset_r,
  input  wire logic               sweep_active_r
);
  // one clock domain, so one default for all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // turn-on edges, split by whether the extra offset is in force
  sequence on_plain_s;
    $rose(synth_on) && !extra_armed_r;
  endsequence
  sequence on_armed_s;
    $rose(synth_on) && extra_armed_r && vco_mhz != 16'h0000;
  endsequence
  // apply request is a single-cycle pulse
  sequence pulse_s;
    phase_apply_r ##1 !phase_apply_r;
  endsequence
  chk_apply_plain_lat: assert property (on_plain_s |-> ##2 pulse_s)
    else $error("plain turn-on apply late or missing");
  chk_apply_armed_lat: assert property (on_armed_s |-> ##50 pulse_s)
    else $error("armed turn-on apply late or missing");
  chk_apply_once_only: assert property (phase_apply_r |->
    $past(synth_on, 2) && !$past(synth_on, 3) || $past(synth_on, 50) && !$past(synth_on, 51))
    else $error("apply without a turn-on");
  chk_shift_holds: assert property (!phase_apply_r |-> $stable(phase_shift_r))
    else $error("phase shift moved between applies");
  chk_arm_on_write: assert property (host_wr.en && host_wr.data != 8'h00 &&
    host_wr.addr inside {16'h0690, 16'h0691} |=> extra_armed_r)
    else $error("nonzero phase write did not arm");
  chk_arm_sticky: assert property (extra_armed_r |=> extra_armed_r)
    else $error("extra offset dropped");
  chk_load_no_arm: assert property (!extra_armed_r && !host_wr.en |=> !extra_armed_r)
    else $error("armed without a host write");
  chk_sweep_off: assert property (!synth_on |=> !sweep_active_r && freq_offset_r == 18'h0)
    else $error("sweep runs while off");
  chk_sweep_start: assert property ($rose(sweep_active_r) |-> freq_offset_r == 18'h0)
    else $error("sweep did not start at nominal");
  chk_unmapped_read: assert property (host_rd_en && !(host_rd_addr inside
    {16'h0690, 16'h0691, [16'h0694:16'h0697]}) |=> host_rd_data_r == 8'h00)
    else $error("unmapped read not zero");
endmodule : sps_ctrl_assertions

// >>> test/sps_ctrl_tb_top.sv
// self-checking bench for the phase and spread control
`timescale 1ns/1ps
module sps_ctrl_tb_top;
  logic               core_clk = 1'b0;  // 200 MHz core clock
  logic               rst = 1'b1;       // synchronous reset
  sps_pkg::sps_wr_t   host_wr = '0;     // host byte writes
  sps_pkg::sps_wr_t   load_wr = '0;     // loader byte writes
  logic               host_rd_en = 1'b0;
  logic [15:0]        host_rd_addr = 16'h0000;
  logic [7:0]         host_rd_data_r;
  logic               synth_on = 1'b0;
  logic [15:0]        vco_mhz = 16'h2EE0;
  logic               phase_apply_r, extra_armed_r, sweep_active_r;
  logic signed [17:0] phase_shift_r, freq_offset_r;
  int                 errors = 0, total_checks = 0, cycles = 0;
  int                 mreg [8] = '{default: 0};  // model bytes 0x690..0x697
  bit                 m_armed = 1'b0;            // model: extra offset in force

  sps_ctrl u_dut (.core_clk(core_clk), .rst(rst), .host_wr(host_wr), .host_rd_en(host_rd_en),
    .host_rd_addr(host_rd_addr), .host_rd_data_r(host_rd_data_r), .load_wr(load_wr),
    .synth_on(synth_on), .vco_mhz(vco_mhz), .phase_apply_r(phase_apply_r),
    .phase_shift_r(phase_shift_r), .extra_armed_r(extra_armed_r),
    .freq_offset_r(freq_offset_r), .sweep_active_r(sweep_active_r));

  always #2.5 core_clk = ~core_clk;
  // hang guard at 90000 cycles, about twice the whole run; the longest sweep period is only about 8100 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // inputs always move 1 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one byte write from host or loader, mirrored into the model
  task automatic wr(input bit ld, input int a, input int d);
    sps_pkg::sps_wr_t w;
    w = '{1'b1, a[15:0], d[7:0]};
    if (ld)
      load_wr = w;
    else
      host_wr = w;
    tick();
    host_wr.en = 1'b0;
    load_wr.en = 1'b0;
    if (a inside {[16'h0690:16'h0691], [16'h0694:16'h0697]})
      mreg[a - 16'h0690] = d & 255;
    if (!ld && a inside {16'h0690, 16'h0691} && (mreg[0] | mreg[1]) != 0)
      m_armed = 1'b1;
    tick();
  endtask : wr

  // read one byte and compare with the model; unmapped reads give zero
  task automatic rd(input int a);
    host_rd_en = 1'b1;
    host_rd_addr = a[15:0];
    tick();
    host_rd_en = 1'b0;
    check(host_rd_data_r, (a inside {[16'h0690:16'h0691], [16'h0694:16'h0697]}) ?
      mreg[a - 16'h0690] : 0);
    tick();
  endtask : rd

  // clamped extra offset in ps, negative above the 12 GHz knee
  function automatic int extra(input int vco);
    longint d, m;
    d = 12000 - vco;
    m = 64'd389_000_000 * (d < 0 ? -d : d) / (vco * vco);
    if (m > 32767)
      m = 32767;
    return (d < 0) ? -int'(m) : int'(m);
  endfunction : extra

  // true when x lies within t of e, on either side
  function automatic bit near(input int x, input int e, input int t);
    return ((x - e) <= t) && ((e - x) <= t);
  endfunction : near

  // write the offset, turn on, check one apply with the right shift
  task automatic phase_case(input bit ld, input int ph, input int vco);
    int exp, n;
    wr(ld, 16'h0690, (ph >> 8) & 255);
    wr(ld, 16'h0691, ph & 255);
    check(extra_armed_r, m_armed);
    exp = ((ph & 65535) ^ 32768) - 32768;
    if (m_armed)
      exp += extra(vco);
    vco_mhz = vco[15:0];
    synth_on = 1'b1;
    for (n = 0; n < 60 && phase_apply_r !== 1'b1; n++)
      tick();
    check(phase_shift_r, exp);
    n = 0;
    repeat (80)
    begin
      tick();
      n += (phase_apply_r === 1'b1);
    end
    check(n, 0);
    synth_on = 1'b0;
    tick(3);
  endtask : phase_case

  // program a sweep, run one period, compare extremes and timing
  task automatic sweep(input int md, input int rate, input int dep);
    int v[4];
    int p, f, lo, hi, tlo, first, amp, tol, ok;
    ok = rate >= 100 && rate <= 220 && dep >= 1 && dep <= 200;
    v = '{md, rate >> 8, rate & 255, dep};
    for (int i = 0; i < 4; i++)
    begin
      wr(0, 16'h0694 + i, v[i]);
      rd(16'h0694 + i);
    end
    synth_on = 1'b1;
    tick();
    check(sweep_active_r, ok);
    p = 64'h1_0000_0000 / (rate * sps_pkg::ACC_STEP);
    lo = 0;
    hi = 0;
    tlo = 0;
    first = 0;
    for (int i = 0; i < p; i++)
    begin
      tick();
      f = freq_offset_r;
      if (f < lo)
        tlo = i;
      lo = (f < lo) ? f : lo;
      hi = (f > hi) ? f : hi;
      first = (first == 0) ? f : first;
    end
    amp = ok ? dep * 256 : 0;
    tol = amp / 16 + 4;
    check(near(lo, md ? -amp : -amp / 2, tol), 1);
    check(near(hi, md ? 0 : amp / 2, tol), 1);
    check(first <= 0, 1);
    if (ok)
      check(near(tlo, p * (md ? 2 : 1) / 4, p / 16), 1);
    synth_on = 1'b0;
    tick(2);
    check(sweep_active_r, 0);
    $display("test sweep mode %0d rate %0d depth %0d done", md, rate, dep);
  endtask : sweep

  initial
  begin
    void'($urandom(32'h9CA673E0));
    tick(10);
    rst = 1'b0;
    for (int a = 16'h068F; a <= 16'h0698; a++)
      rd(a);
    $display("test reset_values done");
    phase_case(1, 16'h1234, 12114);
    wr(0, 16'h0692, 16'h00A5);
    rd(16'h0692);
    phase_case(0, 0, 12114);
    phase_case(0, -200, 12114);
    phase_case(0, 16'h7FFF, 12000);
    phase_case(0, 100 - extra(11500), 11500);
    repeat (5)
      phase_case(0, int'($urandom_range(65535)), int'($urandom_range(16000, 6000)));
    $display("test phase done");
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    mreg = '{default: 0};
    m_armed = 1'b0;
    check(extra_armed_r, 0);
    phase_case(1, 16'h0100, 9000);
    $display("test second_reset done");
    // host and loader hit the depth byte together: the host byte is kept
    host_wr = '{1'b1, 16'h0697, 8'h3C};
    load_wr = '{1'b1, 16'h0697, 8'hC3};
    tick();
    host_wr.en = 1'b0;
    load_wr.en = 1'b0;
    mreg[7] = 8'h3C;
    tick();
    rd(16'h0697);
    $display("test write_collision done");
    sweep(0, 220, 200);
    sweep(1, 100, 1);
    sweep(int'($urandom_range(1)), int'($urandom_range(220, 100)),
      int'($urandom_range(200, 1)));
    sweep(0, 99, 50);
    sweep(1, 221, 50);
    sweep(0, 150, 0);
    sweep(1, 150, 201);
    final_report();
  end
endmodule : sps_ctrl_tb_top

bind sps_ctrl sps_ctrl_assertions u_chk (.core_clk(core_clk), .rst(rst), .host_wr(host_wr),
  .host_rd_en(host_rd_en), .host_rd_addr(host_rd_addr), .host_rd_data_r(host_rd_data_r),
  .load_wr(load_wr), .synth_on(synth_on), .vco_mhz(vco_mhz), .phase_apply_r(phase_apply_r),
  .phase_shift_r(phase_shift_r), .extra_armed_r(extra_armed_r),
  .freq_offset_r(freq_offset_r), .sweep_active_r(sweep_active_r));
